// >>> dv/ssdp_top_bench.sv
// Purpose: directed tests
// Assumes: rows 0 and 4 preloaded
// Notes: at least one idle edge between requests
`timescale 1ns/1ps
`default_nettype none
module ssdp_top_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] mode = 5'h01;
    logic [2:0] shape = 3'h6;
    logic c2en = 1'b1;
    logic oc2 = 1'b0;
    logic byp = 1'b0;
    logic clr = 1'b0;
    logic we, re, full, empty;
    logic [8:0] ad;
    logic [17:0] wd, rd;
    int n_fail = 0;
    int n_checks = 0;
    always #4 clk = ~clk;
    ssdp_user ssdp_user_i (.clk(clk), .we(we), .re(re), .ad(ad), .wd(wd));
    ssdp_top #(.INIT(576'h3C000000000000000015)) ssdp_top_i (.SYS_CLK(clk), .NRST(nrst),
        .MODE(mode), .SHAPE(shape), .CLK1_EN(1'b1), .CLK2_EN(c2en), .RD_ON_CLK2(1'b0),
        .OUT_ON_CLK2(oc2), .OUT_BYPASS(byp), .OUT_CLR(clr), .WR_EN(we), .WR_ADDR(ad),
        .WR_DATA(wd), .RD_EN(re), .RD_ADDR(ad), .RD_DATA(rd), .FIFO_FULL(full),
        .FIFO_EMPTY(empty));
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
            n_fail++;
        end
    endtask
    task automatic rq(input logic w, input logic [8:0] a, input logic [17:0] d,
        input logic [17:0] e, input int lat);
        ssdp_user_i.req(w, 1'b1, a, d);
        repeat (lat) @(posedge clk);
        #1 chk(rd, e);
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(rd, 18'h0);
        rq(1'b0, 9'h0, 18'h0, 18'h00015, 2);
        rq(1'b1, 9'h0, 18'h3ABCD, 18'h00015, 2);
        rq(1'b0, 9'h0, 18'h0, 18'h3ABCD, 2);
        ssdp_user_i.req(1'b1, 1'b0, 9'h5, 18'h25A5A);
        rq(1'b0, 9'h5, 18'h0, 18'h25A5A, 2);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        #1 chk(rd, 18'h0);
        rq(1'b0, 9'h0, 18'h0, 18'h3ABCD, 2);
        @(posedge clk) oc2 <= 1'b1;
        c2en <= 1'b0;
        rq(1'b0, 9'h5, 18'h0, 18'h3ABCD, 2);
        @(posedge clk) c2en <= 1'b1;
        // A read whose output edge found clock two idle is lost; the old word stays
        @(posedge clk) #1 chk(rd, 18'h3ABCD);
        rq(1'b0, 9'h5, 18'h0, 18'h25A5A, 2);
        @(posedge clk) oc2 <= 1'b0;
        byp <= 1'b1;
        rq(1'b0, 9'h0, 18'h0, 18'h3ABCD, 1);
        @(posedge clk) clr <= 1'b1;
        #1 chk(rd, 18'h0);
        @(posedge clk) clr <= 1'b0;
        byp <= 1'b0;
        mode <= 5'h08;
        ssdp_user_i.req(1'b1, 1'b0, 9'h4, 18'h1FFFF);
        rq(1'b0, 9'h4, 18'h0, 18'h0003C, 2);
        @(posedge clk) mode <= 5'h01;
        shape <= 3'h0;
        ssdp_user_i.req(1'b1, 1'b0, 9'h1, 18'h1);
        rq(1'b0, 9'h1, 18'h0, 18'h1, 2);
        @(posedge clk) shape <= 3'h6;
        rq(1'b0, 9'h0, 18'h0, 18'h3ABCF, 2);
        @(posedge clk) mode <= 5'h04;
        @(posedge clk) #1 chk({17'h0, empty}, 18'h1);
        chk({17'h0, full}, 18'h0);
        ssdp_user_i.req(1'b1, 1'b0, 9'h0, 18'h12345);
        #1 chk({17'h0, empty}, 18'h0);
        rq(1'b0, 9'h0, 18'h0, 18'h12345, 2);
        chk({17'h0, empty}, 18'h1);
        @(posedge clk) mode <= 5'h02;
        rq(1'b0, 9'h5, 18'h0, 18'h25A5A, 2);
        give_verdict();
    end
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> dv/ssdp_top_monitor.sv
// Purpose: port checker
// Assumes: one clock, sync reset
// Notes: read data lands three edges after the request edge
`timescale 1ns/1ps
`default_nettype none
module ssdp_monitor (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [4:0] MODE,
    input wire logic CLK2_EN,
    input wire logic OUT_ON_CLK2,
    input wire logic OUT_BYPASS,
    input wire logic OUT_CLR,
    input wire logic RD_EN,
    input wire logic [17:0] RD_DATA,
    input wire logic FIFO_FULL,
    input wire logic FIFO_EMPTY
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    a_reset_zero: assert property (disable iff (1'b0) !NRST |=> RD_DATA == 18'h0)
        else $error("output not zero after reset");
    a_clear_zero: assert property (OUT_CLR && !OUT_BYPASS ##1 !OUT_BYPASS |-> RD_DATA == 18'h0)
        else $error("clear left output set");
    a_bypass_clear: assert property (OUT_BYPASS && OUT_CLR |-> RD_DATA == 18'h0)
        else $error("bypass output not cleared");
    a_idle_hold: assert property ((!RD_EN && !OUT_CLR && !OUT_BYPASS && MODE == 5'h01) [*5]
        |-> $stable(RD_DATA)) else $error("output moved without a read");
    a_clock_two_hold: assert property (OUT_ON_CLK2 && !CLK2_EN && !OUT_CLR && !OUT_BYPASS
        ##1 !OUT_BYPASS |-> $stable(RD_DATA)) else $error("output moved without clock two");
    a_bypass_hold: assert property ((OUT_BYPASS && !RD_EN && !OUT_CLR && MODE == 5'h01) [*3]
        |-> $stable(RD_DATA)) else $error("bypass data moved");
    a_fifo_flags_off: assert property (MODE != 5'h04 |-> !FIFO_FULL && !FIFO_EMPTY)
        else $error("fifo flag outside fifo mode");
    a_fifo_flags_excl: assert property (MODE == 5'h04 |-> !(FIFO_FULL && FIFO_EMPTY))
        else $error("fifo full and empty");
    cover property (RD_EN ##3 RD_DATA != 18'h0);
    cover property (OUT_CLR && !OUT_BYPASS);
    cover property (OUT_BYPASS && RD_EN);
endmodule
bind ssdp_top ssdp_monitor ssdp_monitor_i (.SYS_CLK, .NRST, .MODE, .CLK2_EN, .OUT_ON_CLK2,
    .OUT_BYPASS, .OUT_CLR, .RD_EN, .RD_DATA, .FIFO_FULL, .FIFO_EMPTY);
`default_nettype wire

// >>> dv/ssdp_user.sv
// Purpose: user logic driving the strobes
// Assumes: one shared address for both ports
// Notes: released address and data lines show the inverse
`timescale 1ns/1ps
`default_nettype none
module ssdp_user (
    input wire logic clk,
    output logic we,
    output logic re,
    output logic [8:0] ad,
    output logic [17:0] wd
);
    initial begin
        we = 1'b0;
        re = 1'b0;
        ad = 9'h0;
        wd = 18'h0;
    end
    task automatic req(input logic w, input logic r, input logic [8:0] a, input logic [17:0] d);
        @(posedge clk);
        we <= w;
        re <= r;
        ad <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
        re <= 1'b0;
        ad <= ~a;
        wd <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> hdl/ssdp_defines.vh
// Purpose: constants for the small simple dual-port memory block
// Assumes: one clock domain, 576-bit array
// Notes: shapes are coded as a width select
`ifndef SSDP_DEFINES_VH
`define SSDP_DEFINES_VH
`define SSDP_BITS 576
`define SSDP_ROWS 32
`define SSDP_ROW_W 18
`define SSDP_ADDR_W 9
`define SSDP_DATA_W 18
`define SSDP_SHAPE_W 3
`define SSDP_SHAPE_1 3'h0
`define SSDP_SHAPE_2 3'h1
`define SSDP_SHAPE_4 3'h2
`define SSDP_SHAPE_8 3'h3
`define SSDP_SHAPE_9 3'h4
`define SSDP_SHAPE_16 3'h5
`define SSDP_SHAPE_18 3'h6
`define SSDP_MODE_W 5
`define SSDP_MODE_SDP 5'h01
`define SSDP_MODE_SP 5'h02
`define SSDP_MODE_FIFO 5'h04
`define SSDP_MODE_ROM 5'h08
`define SSDP_MODE_SHIFT 5'h10
`define SSDP_PTR_W 6
`endif

// >>> hdl/ssdp_mem.v
// Purpose: 32 x 18 storage array with registered read data
// Assumes: single clock, bit-level write mask
// Notes: contents start from an init vector; only load, which the top raises in reset, reseeds the array
`timescale 1ns/1ps
`default_nettype none
`include "ssdp_defines.vh"
module ssdp_mem #(
    parameter [`SSDP_BITS-1:0] INIT = {`SSDP_BITS{1'b0}}
) (
    input wire clk,
    input wire load,
    input wire we,
    input wire [4:0] waddr,
    input wire [`SSDP_ROW_W-1:0] wmask,
    input wire [`SSDP_ROW_W-1:0] wdata,
    input wire re,
    input wire [4:0] raddr,
    output reg [`SSDP_ROW_W-1:0] rdata_ff
);
    reg [`SSDP_ROW_W-1:0] mem [0:`SSDP_ROWS-1];
    integer i;
    always @(posedge clk) begin
        // Read before write gives old data on a collision
        if (re) begin
            rdata_ff <= mem[raddr];
        end
        for (i = 0; i < `SSDP_ROWS; i = i + 1) begin
            if (load) begin
                mem[i] <= INIT[i*`SSDP_ROW_W +: `SSDP_ROW_W];
            end else if (we && (waddr == i[4:0])) begin
                mem[i] <= (mem[i] & ~wmask) | (wdata & wmask);
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/ssdp_top.v
// Purpose: small simple dual-port memory with RAM, ROM, FIFO and shift modes
// Assumes: inputs synchronous to SYS_CLK; second clock arrives as an enable
// Notes: shapes fold onto one 32 x 18 array by address and bit lane
`timescale 1ns/1ps
`default_nettype none
`include "ssdp_defines.vh"
// Summary of operation
// - The array holds 576 bits; only the x9 and x18 shapes reach all of them, the other shapes use 512.
// - One write port and one read port only, no second read/write port.
// - Mode select: simple dual-port, single-port, FIFO, ROM or shift register.
// - Shapes 512x1 through 32x18 select the word width and depth.
// - RAM and ROM start with preloaded contents until overwritten.
// - Write strobe, data and address registers share the input clock.
// - Read address, read strobe and output registers pick either clock.
// - Read/write clocking or input/output clocking where only output uses clock two.
// - Only the output register can be bypassed; input registers always stay.
module ssdp_top #(
    parameter [`SSDP_BITS-1:0] INIT = {`SSDP_BITS{1'b0}}
) (
    input wire SYS_CLK,
    input wire NRST,
    input wire [`SSDP_MODE_W-1:0] MODE,
    input wire [`SSDP_SHAPE_W-1:0] SHAPE,
    input wire CLK1_EN,
    input wire CLK2_EN,
    input wire RD_ON_CLK2,
    input wire OUT_ON_CLK2,
    input wire OUT_BYPASS,
    input wire OUT_CLR,
    input wire WR_EN,
    input wire [`SSDP_ADDR_W-1:0] WR_ADDR,
    input wire [`SSDP_DATA_W-1:0] WR_DATA,
    input wire RD_EN,
    input wire [`SSDP_ADDR_W-1:0] RD_ADDR,
    output wire [`SSDP_DATA_W-1:0] RD_DATA,
    output wire FIFO_FULL,
    output wire FIFO_EMPTY
);
    reg wen_ff, ren_ff, load_ff, rvalid_ff;
    reg [`SSDP_ADDR_W-1:0] waddr_ff, raddr_ff, rlane_ff;
    reg [`SSDP_DATA_W-1:0] wdata_ff, out_ff;
    reg [`SSDP_PTR_W:0] wptr_ff, rptr_ff;
    reg [`SSDP_PTR_W-1:0] shptr_ff;
    wire [`SSDP_ROW_W-1:0] mem_rdata;
    wire is_rom = (MODE == `SSDP_MODE_ROM);
    wire is_sp = (MODE == `SSDP_MODE_SP);
    wire is_fifo = (MODE == `SSDP_MODE_FIFO);
    wire is_shift = (MODE == `SSDP_MODE_SHIFT);
    // Read side registers follow the chosen clock enable
    wire rd_ce = RD_ON_CLK2 ? CLK2_EN : CLK1_EN;
    wire out_ce = (OUT_ON_CLK2 || RD_ON_CLK2) ? CLK2_EN : CLK1_EN;
    wire [`SSDP_PTR_W:0] fifo_cnt = wptr_ff - rptr_ff;
    wire [`SSDP_PTR_W:0] fifo_depth = (SHAPE == `SSDP_SHAPE_8 || SHAPE == `SSDP_SHAPE_9) ?
                                      7'h40 : 7'h20;
    assign FIFO_FULL = is_fifo && (fifo_cnt == fifo_depth);
    assign FIFO_EMPTY = is_fifo && (fifo_cnt == 7'h00);
    // Effective write/read strobes; ROM blocks writes
    wire wr_req = WR_EN && !is_rom && !(is_fifo && FIFO_FULL);
    wire rd_req = is_shift ? WR_EN : (is_fifo ? (RD_EN && !FIFO_EMPTY) : RD_EN);
    reg [`SSDP_ADDR_W-1:0] nxt_waddr, nxt_raddr;
    always @* begin
        nxt_waddr = WR_ADDR;
        nxt_raddr = is_sp ? WR_ADDR : RD_ADDR;
        if (is_fifo) begin
            nxt_waddr = {3'h0, wptr_ff[`SSDP_PTR_W-1:0]};
            nxt_raddr = {3'h0, rptr_ff[`SSDP_PTR_W-1:0]};
        end else if (is_shift) begin
            nxt_waddr = {3'h0, shptr_ff};
            nxt_raddr = {3'h0, shptr_ff};
        end
    end
    // Input registers always stay in the path
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            wen_ff <= 1'b0;
            waddr_ff <= 9'h000;
            wdata_ff <= 18'h00000;
            wptr_ff <= 7'h00;
            shptr_ff <= 6'h00;
            load_ff <= 1'b1;
        end else begin
            load_ff <= 1'b0;
            if (CLK1_EN) begin
                wen_ff <= wr_req;
                waddr_ff <= nxt_waddr;
                wdata_ff <= WR_DATA;
                if (is_fifo && wr_req) begin
                    wptr_ff <= wptr_ff + 7'h01;
                end
                if (is_shift && WR_EN) begin
                    shptr_ff <= (shptr_ff + 6'h01) & (fifo_depth[`SSDP_PTR_W-1:0] - 6'h01);
                end
            end else begin
                wen_ff <= 1'b0;
            end
        end
    end
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            ren_ff <= 1'b0;
            raddr_ff <= 9'h000;
            rptr_ff <= 7'h00;
        end else if (rd_ce) begin
            ren_ff <= rd_req;
            raddr_ff <= nxt_raddr;
            if (is_fifo && rd_req) begin
                rptr_ff <= rptr_ff + 7'h01;
            end
        end else begin
            ren_ff <= 1'b0;
        end
    end
    // Shape maps logical address to row and bit lane of the 32x18 array
    function [4:0] row_of;
        input [`SSDP_SHAPE_W-1:0] s;
        input [`SSDP_ADDR_W-1:0] a;
        begin
            case (s)
                `SSDP_SHAPE_1: row_of = a[8:4];
                `SSDP_SHAPE_2: row_of = a[7:3];
                `SSDP_SHAPE_4: row_of = a[6:2];
                `SSDP_SHAPE_8: row_of = a[5:1];
                `SSDP_SHAPE_9: row_of = a[5:1];
                default: row_of = a[4:0];
            endcase
        end
    endfunction
    function [4:0] lane_of;
        input [`SSDP_SHAPE_W-1:0] s;
        input [`SSDP_ADDR_W-1:0] a;
        begin
            case (s)
                `SSDP_SHAPE_1: lane_of = {1'b0, a[3:0]};
                `SSDP_SHAPE_2: lane_of = {1'b0, a[2:0], 1'b0};
                `SSDP_SHAPE_4: lane_of = {1'b0, a[1:0], 2'h0};
                `SSDP_SHAPE_8: lane_of = a[0] ? 5'h08 : 5'h00;
                `SSDP_SHAPE_9: lane_of = a[0] ? 5'h09 : 5'h00;
                default: lane_of = 5'h00;
            endcase
        end
    endfunction
    function [`SSDP_DATA_W-1:0] wmask_of;
        input [`SSDP_SHAPE_W-1:0] s;
        begin
            case (s)
                `SSDP_SHAPE_1: wmask_of = 18'h00001;
                `SSDP_SHAPE_2: wmask_of = 18'h00003;
                `SSDP_SHAPE_4: wmask_of = 18'h0000F;
                `SSDP_SHAPE_8: wmask_of = 18'h000FF;
                `SSDP_SHAPE_9: wmask_of = 18'h001FF;
                `SSDP_SHAPE_16: wmask_of = 18'h0FFFF;
                default: wmask_of = 18'h3FFFF;
            endcase
        end
    endfunction
    wire [4:0] wlane = lane_of(SHAPE, waddr_ff);
    wire [`SSDP_DATA_W-1:0] wmask = wmask_of(SHAPE) << wlane;
    wire [`SSDP_DATA_W-1:0] wshift = wdata_ff << wlane;
    // Array stays intact under clear; reset raises the load, which reseeds it from INIT
    ssdp_mem #(.INIT(INIT)) u_mem (
        .clk(SYS_CLK),
        .load(load_ff),
        .we(wen_ff),
        .waddr(row_of(SHAPE, waddr_ff)),
        .wmask(wmask),
        .wdata(wshift),
        .re(ren_ff),
        .raddr(row_of(SHAPE, raddr_ff)),
        .rdata_ff(mem_rdata)
    );
    always @(posedge SYS_CLK) begin
        if (!NRST) begin
            rlane_ff <= 9'h000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= ren_ff;
            if (ren_ff) begin
                rlane_ff <= {4'h0, lane_of(SHAPE, raddr_ff)};
            end
        end
    end
    wire [`SSDP_DATA_W-1:0] rword = (mem_rdata >> rlane_ff[4:0]) & wmask_of(SHAPE);
    always @(posedge SYS_CLK) begin
        if (!NRST || OUT_CLR) begin
            out_ff <= 18'h00000;
        end else if (out_ce && rvalid_ff) begin
            out_ff <= rword;
        end
    end
    // Bypass exposes the array read word one stage earlier
    assign RD_DATA = OUT_BYPASS ? (OUT_CLR ? 18'h00000 : rword) : out_ff;
endmodule
`default_nettype wire
